//--- src/pmt8_pkg.sv
package pmt8_pkg;

    // register byte offsets on the apb side
    localparam logic [7:0] PERIOD_COUNT_OFS = 8'h00;
    localparam logic [7:0] PERIOD_LIMIT_OFS = 8'h04;
    localparam logic [7:0] TIMER_CONTROL_OFS = 8'h08;
    localparam logic [7:0] IRQ_FLAGS_OFS = 8'h0C;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h10;

    // values after reset
    localparam logic [7:0] PERIOD_COUNT_RST = 8'h00;
    localparam logic [7:0] PERIOD_LIMIT_RST = 8'hFF;
    localparam logic [6:0] TIMER_CONTROL_RST = 7'h00;
    localparam logic [7:0] IRQ_MASK_RST = 8'h00;

    // timer_control field positions
    localparam int PRESCALE_LSB = 0;
    localparam int RUN_BIT = 2;
    localparam int POSTSCALE_LSB = 3;

    // peripheral_irq_flags position of the match flag
    localparam int MATCH_FLAG_BIT = 1;

    // instruction clock is the core clock divided by four
    localparam int INSTR_DIV = 4;

    // prescale terminal counts, ratio minus one
    localparam logic [3:0] PRE_LIM_1 = 4'h0;
    localparam logic [3:0] PRE_LIM_4 = 4'h3;
    localparam logic [3:0] PRE_LIM_16 = 4'hF;

    // prescale select codes
    typedef enum logic [1:0] {
        PMT8_PRE_1 = 2'b00,
        PMT8_PRE_4 = 2'b01,
        PMT8_PRE_16A = 2'b10,
        PMT8_PRE_16B = 2'b11
    } pmt8_pre_sel_t;

    // decoded timer_control contents
    typedef struct packed {
        logic [3:0] output_postscale_select;
        logic timer_run;
        logic [1:0] clock_prescale_select;
    } pmt8_ctrl_t;

    // time base handed to the capture/compare/pwm unit
    typedef struct packed {
        logic match;
        logic [7:0] count;
    } pmt8_base_t;

endpackage

//--- src/pmt8_prescaler.sv
`timescale 1ns/1ps

module pmt8_prescaler (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control
    input wire logic run,
    input wire logic clear,
    input wire logic [1:0] sel,
    // prescaled increment enable
    output logic tick
);

    logic [1:0] quarter_reg;
    logic [1:0] quarter_next;
    logic [3:0] pre_reg;
    logic [3:0] pre_next;
    logic quarter_tick;
    logic [3:0] pre_lim;
    logic pre_done;

    // ratio decode; the upper select bit alone picks sixteen
    function automatic logic [3:0] pre_limit(input logic [1:0] s);
        case (s)
            pmt8_pkg::PMT8_PRE_1: pre_limit = pmt8_pkg::PRE_LIM_1;
            pmt8_pkg::PMT8_PRE_4: pre_limit = pmt8_pkg::PRE_LIM_4;
            default: pre_limit = pmt8_pkg::PRE_LIM_16;
        endcase
    endfunction

    // instruction clock: free running, it belongs to the whole core
    assign quarter_tick = (quarter_reg == 2'(pmt8_pkg::INSTR_DIV - 1));
    assign quarter_next = quarter_tick ? 2'h0 : quarter_reg + 2'h1;
    assign pre_lim = pre_limit(sel);
    assign pre_done = (pre_reg == pre_lim);

    // prescale count holds while stopped, restarts on any clear
    assign pre_next = clear ? 4'h0 :
        (quarter_tick && run) ? (pre_done ? 4'h0 : pre_reg + 4'h1) :
        pre_reg;
    assign tick = quarter_tick && run && pre_done && !clear;

    // counters; reset clears the prescale count
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            quarter_reg <= 2'h0;
            pre_reg <= 4'h0;
        end else begin
            quarter_reg <= quarter_next;
            pre_reg <= pre_next;
        end
    end

endmodule

//--- src/pmt8_timer.sv
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module pmt8_timer (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // time base for the capture/compare/pwm unit
    output pmt8_pkg::pmt8_base_t pwm_base,
    // shift clock source for the sync serial port
    output logic ssp_match_tick,
    // interrupt
    output logic irq
);

    // registers
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic [7:0] limit_reg;
    logic [7:0] limit_next;
    logic [6:0] ctrl_reg;
    logic [6:0] ctrl_next;
    logic [3:0] post_reg;
    logic [3:0] post_next;
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic slverr_reg;
    logic slverr_next;
    logic match_reg;

    // decoded fields and strobes
    pmt8_pkg::pmt8_ctrl_t ctrl;
    logic setup;
    logic access;
    logic wr;
    logic wr_lane0;
    logic mapped;
    logic wr_count;
    logic wr_limit;
    logic wr_ctrl;
    logic wr_flags;
    logic wr_mask;
    logic scaler_clear;
    logic tick;
    logic at_limit;
    logic match;
    logic post_done;
    logic flag_set;
    logic [7:0] flag_set_vec;
    logic [7:0] rd_mux;
    logic sel_count;
    logic sel_limit;
    logic sel_ctrl;
    logic sel_flags;
    logic sel_mask;
    logic run_on;
    logic [1:0] pre_sel;
    logic [3:0] post_sel;
    logic rd_en;
    logic match_raw;
    logic [7:0] count_inc;
    logic [7:0] count_step;
    logic [3:0] post_inc;
    logic [7:0] match_bit_vec;
    logic [7:0] irq_pending;
    logic [31:0] rd_word;

    // address decode, used for both read and write
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // control view of the stored bits, split into named fields
    // so the scalers never index the raw register
    assign ctrl = pmt8_pkg::pmt8_ctrl_t'(ctrl_reg);
    assign run_on = ctrl.timer_run;
    assign pre_sel = ctrl.clock_prescale_select;
    assign post_sel = ctrl.output_postscale_select;

    // apb phases; zero wait states, so pready is only the access phase
    // and no request can ever be stretched by this block
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign pready = access;
    assign wr = access && pwrite;
    assign wr_lane0 = wr && pstrb[0];
    assign rd_en = setup && !pwrite;
    assign mapped = sel_count || sel_limit || sel_ctrl || sel_flags || sel_mask;

    // one select per register, shared by the read and write paths
    // so both sides always agree on the map
    assign sel_count = hit(paddr, pmt8_pkg::PERIOD_COUNT_OFS);
    assign sel_limit = hit(paddr, pmt8_pkg::PERIOD_LIMIT_OFS);
    assign sel_ctrl = hit(paddr, pmt8_pkg::TIMER_CONTROL_OFS);
    assign sel_flags = hit(paddr, pmt8_pkg::IRQ_FLAGS_OFS);
    assign sel_mask = hit(paddr, pmt8_pkg::IRQ_MASK_OFS);

    // write strobes; only byte lane zero carries register bits
    assign wr_count = wr_lane0 && sel_count;
    assign wr_limit = wr_lane0 && sel_limit;
    assign wr_ctrl = wr_lane0 && sel_ctrl;
    assign wr_flags = wr_lane0 && sel_flags;
    assign wr_mask = wr_lane0 && sel_mask;

    // either write restarts both scalers
    assign scaler_clear = wr_count || wr_ctrl;

    // prescaler and instruction clock divider; the divider itself
    // is cleared only by reset, the prescale count behind it also on scaler_clear
    pmt8_prescaler u_prescaler (
        .core_clk(core_clk),
        .rstn(rstn),
        .run(run_on),
        .clear(scaler_clear),
        .sel(pre_sel),
        .tick(tick)
    );

    // period compare; match only on a real increment so a halted
    // timer sitting on the limit raises nothing
    assign at_limit = (count_reg == limit_reg);
    assign match_raw = tick && at_limit;
    assign match = match_raw && !wr_count;

    // counter: a software load beats a simultaneous increment;
    // a load above the limit runs on to the natural wrap
    assign count_inc = count_reg + 8'h01;
    assign count_step = at_limit ? 8'h00 : count_inc;
    assign count_next = wr_count ? pwdata[7:0] :
        tick ? count_step :
        count_reg;

    // postscaler counts matches up to the selected ratio
    // and restarts on the match that completes it
    assign post_inc = post_reg + 4'h1;
    assign post_done = (post_reg == post_sel);
    assign flag_set = match && post_done;
    assign post_next = scaler_clear ? 4'h0 :
        match ? (post_done ? 4'h0 : post_inc) :
        post_reg;

    // other registers; only the match bit of the mask exists
    assign match_bit_vec = 8'(1 << pmt8_pkg::MATCH_FLAG_BIT);
    assign limit_next = wr_limit ? pwdata[7:0] : limit_reg;
    assign ctrl_next = wr_ctrl ? pwdata[6:0] : ctrl_reg;

    // mask bits that do not exist stay zero whatever is written
    generate
        for (genvar m = 0; m < 8; m++) begin : g_mask
            assign mask_next[m] = match_bit_vec[m] && (wr_mask ? pwdata[m] : mask_reg[m]);
        end
    endgenerate

    // sticky flags, write one to clear; a same-cycle set wins
    // so an event landing on the clear is never lost
    assign flag_set_vec = flag_set ? match_bit_vec : 8'h00;
    generate
        for (genvar b = 0; b < 8; b++) begin : g_flag
            assign flags_next[b] = flag_set_vec[b] ||
                (flags_reg[b] && !(wr_flags && pwdata[b]));
        end
    endgenerate

    // read selection; bit seven of control is not stored
    // and unmapped offsets read as zero
    assign rd_mux = sel_count ? count_reg :
        sel_limit ? limit_reg :
        sel_ctrl ? {1'b0, ctrl_reg} :
        sel_flags ? flags_reg :
        sel_mask ? mask_reg :
        8'h00;
    assign rd_word = {24'h000000, rd_mux};

    // read data is captured in the setup cycle and held through access;
    // a count read may therefore be one cycle old when it completes
    assign rdata_next = rd_en ? rd_word : rdata_reg;
    assign slverr_next = setup ? !mapped : slverr_reg;

    // bus outputs and interrupt; irq is a level of stored bits only
    // so it cannot glitch with the bus inputs
    assign prdata = rdata_reg;
    assign pslverr = slverr_reg && access;
    assign irq_pending = flags_reg & mask_reg;
    assign irq = |irq_pending;

    // exported time base; match is registered and goes out with the wrapped count of zero
    assign pwm_base = '{match: match_reg, count: count_reg};
    assign ssp_match_tick = match_reg;

    // live count; every kind of reset clears it
    // because all of them arrive on the one reset input
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count_reg <= pmt8_pkg::PERIOD_COUNT_RST;
        end else begin
            count_reg <= count_next;
        end
    end

    // postscale count restarts from zero on reset
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            post_reg <= 4'h0;
        end else begin
            post_reg <= post_next;
        end
    end

    // registered match, so the far side sees one clean pulse
    // lined up with the count that has just wrapped
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            match_reg <= 1'b0;
        end else begin
            match_reg <= match;
        end
    end

    // period limit
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            limit_reg <= pmt8_pkg::PERIOD_LIMIT_RST;
        end else begin
            limit_reg <= limit_next;
        end
    end

    // control starts stopped, so only the instruction clock divider counts
    // until software sets the run bit
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= pmt8_pkg::TIMER_CONTROL_RST;
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    // sticky flags
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags_reg <= 8'h00;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // interrupt mask
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            mask_reg <= pmt8_pkg::IRQ_MASK_RST;
        end else begin
            mask_reg <= mask_next;
        end
    end

    // read data flop; holds between reads
    // so prdata stays put through the access phase
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 32'h00000000;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // error flop, decided with the read data at setup
    // and only shown while the access phase stands
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slverr_reg <= 1'b0;
        end else begin
            slverr_reg <= slverr_next;
        end
    end

endmodule

//--- dv/pmt8_asserts.sv
`timescale 1ns/1ps
module pmt8_asserts (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // apb request side
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    // timer outputs
    input wire pmt8_pkg::pmt8_base_t pwm_base,
    input wire logic ssp_match_tick,
    input wire logic irq
);
    // access-edge write decode; run copy needed to know when counting must freeze
    wire logic wr = psel && penable && pwrite && pstrb[0];
    wire logic wr_cnt = wr && (paddr == pmt8_pkg::PERIOD_COUNT_OFS);
    logic run_reg;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) run_reg <= 1'b0;
        else if (wr && paddr == pmt8_pkg::TIMER_CONTROL_OFS) run_reg <= pwdata[pmt8_pkg::RUN_BIT];
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_ssp_same: assert property (ssp_match_tick == pwm_base.match)
        else $error("ssp tick differs from match");
    a_match_zero: assert property (pwm_base.match |-> pwm_base.count == 8'h00)
        else $error("match with nonzero count");
    a_match_pulse: assert property (pwm_base.match |=> !pwm_base.match)
        else $error("match longer than one cycle");
    a_count_step: assert property ($changed(pwm_base.count) && !$past(wr_cnt) |->
        pwm_base.count == $past(pwm_base.count) + 8'h01 || pwm_base.count == 8'h00)
        else $error("count moved by other than one");
    a_tick_space: assert property ($changed(pwm_base.count) && !$past(wr_cnt) |=>
        ($stable(pwm_base.count) || $past(wr_cnt))[*3])
        else $error("count ticks closer than four cycles");
    a_irq_cause: assert property ($rose(irq) |-> pwm_base.match ||
        $past(pwm_base.match) || $past(wr && paddr == pmt8_pkg::IRQ_MASK_OFS))
        else $error("irq rose without cause");
    a_irq_sticky: assert property ($fell(irq) |-> $past(wr))
        else $error("irq fell without a write");
    a_stop_hold: assert property (!run_reg && !$past(run_reg) |->
        !pwm_base.match && ($stable(pwm_base.count) || $past(wr_cnt)))
        else $error("stopped timer moved");
endmodule

//--- dv/pmt8_pwm_model.sv
`timescale 1ns/1ps
module pmt8_pwm_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // time base from the timer
    input wire pmt8_pkg::pmt8_base_t pwm_base,
    input wire logic ssp_match_tick,
    // observed totals
    output logic [15:0] n_match,
    output logic shift_clk,
    output logic [15:0] n_skew
);
    // shift clock halves the match rate; skew counts pwm/ssp disagreement
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            n_match <= 16'h0000;
            shift_clk <= 1'b0;
            n_skew <= 16'h0000;
        end else begin
            if (pwm_base.match) n_match <= n_match + 16'h0001;
            if (ssp_match_tick) shift_clk <= ~shift_clk;
            if (ssp_match_tick != pwm_base.match) n_skew <= n_skew + 16'h0001;
        end
    end
endmodule

//--- dv/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pmt8_pkg::pmt8_base_t pwm_base;
    logic ssp_match_tick;
    logic irq;
    logic [15:0] n_match;
    logic [15:0] n_skew;
    logic [15:0] m0;
    logic shift_clk;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int cmp_count = 0;
    int i;
    longint t0;
    logic [7:0] ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
    logic [7:0] re [5] = '{8'h00, 8'hFF, 8'h00, 8'h00, 8'h00};
    always #10 core_clk = ~core_clk;
    pmt8_timer u_pmt8_timer (.*);
    pmt8_pwm_model u_pmt8_pwm_model (.*);
    // apb transfer; waits on pready, takes data at that edge only
    task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        xfer(1'b0, a, 8'h00);
        chk(rd, {24'h000000, e});
    endtask
    task automatic wait_m(input logic [15:0] n);
        m0 = n_match;
        while (n_match != m0 + n) @(posedge core_clk);
    endtask
    task automatic do_reset;
        rstn <= 1'b0;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        for (i = 0; i < 5; i++) rc(ra[i], re[i]);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        do_reset();
        xfer(1'b1, 8'h08, 8'h80);
        rc(8'h08, 8'h00);
        xfer(1'b1, 8'h04, 8'h5A);
        rc(8'h04, 8'h5A);
        pstrb <= 4'hE;
        xfer(1'b1, 8'h04, 8'hA5);
        pstrb <= 4'hF;
        rc(8'h04, 8'h5A);
        xfer(1'b0, 8'h20, 8'h00);
        chk({31'h0, err}, 32'h1);
        xfer(1'b1, 8'h00, 8'h37);
        repeat (40) @(posedge core_clk);
        rc(8'h00, 8'h37);
        // rewrites come faster than a 1:16 tick, so a cleared prescaler never fires
        for (i = 0; i < 6; i++) begin
            xfer(1'b1, 8'h08, 8'h07);
            repeat (30) @(posedge core_clk);
        end
        rc(8'h00, 8'h37);
        for (i = 0; i < 6; i++) begin
            xfer(1'b1, 8'h00, 8'h00);
            repeat (30) @(posedge core_clk);
        end
        rc(8'h00, 8'h00);
        $display("test registers and scaler clear done");
        // period is 4 * (limit + 1) * prescale, measured match to match
        xfer(1'b1, 8'h04, 8'h03);
        for (i = 0; i < 4; i++) begin
            xfer(1'b1, 8'h08, 8'h04 | 8'(i));
            wait_m(16'h0001);
            t0 = $time;
            wait_m(16'h0001);
            chk(32'(($time - t0) / 20), 16 * ((i == 0) ? 1 : (i == 1) ? 4 : 16));
        end
        $display("test prescale periods done");
        xfer(1'b1, 8'h08, 8'h00);
        xfer(1'b1, 8'h04, 8'h01);
        xfer(1'b1, 8'h00, 8'h00);
        xfer(1'b1, 8'h0C, 8'h02);
        xfer(1'b1, 8'h10, 8'h02);
        m0 = n_match;
        xfer(1'b1, 8'h08, 8'h14);
        while (irq !== 1'b1) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk(32'(n_match - m0), 32'h3);
        m0 = n_match;
        xfer(1'b1, 8'h10, 8'h00);
        rc(8'h0C, 8'h02);
        chk({31'h0, irq}, 32'h0);
        xfer(1'b1, 8'h0C, 8'h02);
        xfer(1'b1, 8'h10, 8'h02);
        while (irq !== 1'b1) @(posedge core_clk);
        repeat (2) @(posedge core_clk);
        chk(32'(n_match - m0), 32'h3);
        $display("test postscale and irq done");
        chk({16'h0000, n_skew}, 32'h0);
        chk({31'h0, shift_clk}, {31'h0, n_match[0]});
        do_reset();
        $display("test mid-run reset done");
        results();
    end
    // watchdog well beyond the fewer than two thousand cycles the tests need
    initial begin
        repeat (10000) @(posedge core_clk);
        n_errors++;
        results();
    end
endmodule
bind pmt8_timer pmt8_asserts u_pmt8_asserts (.*);
